/* shared/sfw_pkg.sv */
/*
 * Constants and types for the status flags word.
 * Assumes one core clock; all users refer to names as sfw_pkg::name.
 */
package sfw_pkg;

    // ********************************************************
    // Bus widths and register offsets
    // ********************************************************
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 8;
    localparam logic [7:0]  OFF_STATUS     = 8'h00;
    localparam logic [7:0]  OFF_BIT_ACCESS = 8'h01;
    localparam logic [7:0]  OFF_BANK_BASE  = 8'h02;

    // ********************************************************
    // Field positions in the status word
    // ********************************************************
    localparam int unsigned BIT_PARITY     = 0;
    localparam int unsigned BIT_USER_ONE   = 1;
    localparam int unsigned BIT_OVERFLOW   = 2;
    localparam int unsigned BIT_BANK_LOW   = 3;
    localparam int unsigned BIT_BANK_HIGH  = 4;
    localparam int unsigned BIT_USER_ZERO  = 5;

    // Bit access word: index in [2:0], value in bit 3
    localparam int unsigned BA_INDEX_LSB   = 0;
    localparam int unsigned BA_INDEX_MSB   = 2;
    localparam int unsigned BA_VALUE_BIT   = 3;

    // ********************************************************
    // Reset values and arithmetic limits
    // ********************************************************
    localparam logic        RST_FLAG       = 1'b0;
    localparam logic [1:0]  RST_BANK       = 2'h0;
    localparam logic [7:0]  RST_DATA       = 8'h00;
    localparam int unsigned BANK_SHIFT     = 3;
    localparam logic [15:0] PRODUCT_LIMIT  = 16'h00ff;

    // ********************************************************
    // Arithmetic instructions that touch the overflow flag
    // ********************************************************
    typedef enum logic [2:0] {
        SFW_OP_ADD,
        SFW_OP_SUM_WITH_CARRY,
        SFW_OP_SUBTRACT_WITH_BORROW,
        SFW_OP_PRODUCT,
        SFW_OP_DIVIDE
    } sfw_op_e;

endpackage

/* src/sfw_parity.sv */
/*
 * Odd parity of a word, purely combinational.
 * Assumes the input is stable within the cycle it is used.
 */
`timescale 1ns/100ps

module sfw_parity #(
    parameter int unsigned WIDTH = 8
) (
    // Word in
    input  wire logic [WIDTH-1:0] data_i,
    // Odd parity out
    output wire logic             odd_o
);

    // One when the count of ones is odd
    assign odd_o = ^data_i;

endmodule

/* src/sfw_status_word.sv */
/*
 * Low part of the processor status word: user flags, bank selector,
 * overflow flag and accumulator parity, with a simple register port.
 * Assumes the accumulator and instruction inputs come from logic on
 * clock_i, so they are used without synchronisers.
 */
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps

// Overview of operation
// - Two user flags, changed only by software
// - Bank selector picks one of four windows
// - Add family signed overflow sets overflow
// - Product above 255 sets overflow
// - Divide by zero sets overflow
// - Otherwise those instructions clear overflow
// - Parity is one for odd accumulator ones
module sfw_status_word (
    // Clock and reset
    input  wire logic                        clock_i,
    input  wire logic                        reset_n_i,
    // Register port
    input  wire logic [sfw_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic [sfw_pkg::DATA_W-1:0]  wr_data_i,
    input  wire logic                        wr_strobe_i,
    input  wire logic                        rd_strobe_i,
    output logic      [sfw_pkg::DATA_W-1:0]  rd_data_o,
    // Datapath side
    input  wire logic                        op_valid_i,
    input  wire sfw_pkg::sfw_op_e            op_kind_i,
    input  wire logic [7:0]                  operand_a_i,
    input  wire logic [7:0]                  operand_b_i,
    input  wire logic                        carry_in_i,
    input  wire logic [7:0]                  accumulator_i,
    // Status outputs
    output logic                             user_flag_zero_o,
    output logic                             user_flag_one_o,
    output logic [1:0]                       bank_select_o,
    output logic [7:0]                       bank_base_o,
    output logic                             overflow_flag_o,
    output logic                             parity_flag_o,
    output logic [7:0]                       status_word_o
);

    // ********************************************************
    // Declarations
    // ********************************************************
    logic        user_flag_zero_reg;
    logic        user_flag_zero_next;
    logic        user_flag_one_reg;
    logic        user_flag_one_next;
    logic [1:0]  bank_select_reg;
    logic [1:0]  bank_select_next;
    logic        overflow_flag_reg;
    logic        overflow_flag_next;
    logic        parity_reg;
    logic        parity_next;
    logic [7:0]  bank_base_reg;
    logic [7:0]  bank_base_next;
    logic [7:0]  status_word_reg;
    logic [7:0]  status_word_next;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_data_next;
    logic        parity_now;
    logic [8:0]  sum_wide;
    logic [8:0]  diff_wide;
    logic [15:0] product_wide;
    logic        add_overflow;
    logic        sub_overflow;
    logic        op_overflow;
    logic        wr_status;
    logic        wr_bit;
    logic [2:0]  bit_index;
    logic        bit_value;

    // ********************************************************
    // Parity of the accumulator
    // ********************************************************
    // Follows the accumulator within the same cycle
    sfw_parity #(
        .WIDTH (8)
    ) u_parity (
        .data_i (accumulator_i),
        .odd_o  (parity_now)
    );

    // ********************************************************
    // Overflow detection for the arithmetic instructions
    // ********************************************************
    // Carry only enters for the carry and borrow forms
    always_comb begin
        sum_wide     = {1'b0, operand_a_i} + {1'b0, operand_b_i}
                     + {8'h00, carry_in_i & (op_kind_i == sfw_pkg::SFW_OP_SUM_WITH_CARRY)};
        diff_wide    = {1'b0, operand_a_i} - {1'b0, operand_b_i} - {8'h00, carry_in_i};
        product_wide = {8'h00, operand_a_i} * {8'h00, operand_b_i};
        // Same signs in, different sign out
        add_overflow = (operand_a_i[7] == operand_b_i[7])
                     && (sum_wide[7] != operand_a_i[7]);
        // Different signs in, sign of result not that of a
        sub_overflow = (operand_a_i[7] != operand_b_i[7])
                     && (diff_wide[7] != operand_a_i[7]);
        case (op_kind_i)
            sfw_pkg::SFW_OP_ADD,
            sfw_pkg::SFW_OP_SUM_WITH_CARRY: begin
                op_overflow = add_overflow;
            end
            sfw_pkg::SFW_OP_SUBTRACT_WITH_BORROW: begin
                op_overflow = sub_overflow;
            end
            sfw_pkg::SFW_OP_PRODUCT: begin
                op_overflow = product_wide > sfw_pkg::PRODUCT_LIMIT;
            end
            sfw_pkg::SFW_OP_DIVIDE: begin
                op_overflow = operand_b_i == 8'h00;
            end
            default: begin
                op_overflow = 1'b0;
            end
        endcase
    end

    // ********************************************************
    // Write decode
    // ********************************************************
    assign wr_status = wr_strobe_i && (addr_i == sfw_pkg::OFF_STATUS);
    assign wr_bit    = wr_strobe_i && (addr_i == sfw_pkg::OFF_BIT_ACCESS);
    assign bit_index = wr_data_i[sfw_pkg::BA_INDEX_MSB:sfw_pkg::BA_INDEX_LSB];
    assign bit_value = wr_data_i[sfw_pkg::BA_VALUE_BIT];

    // ********************************************************
    // Status bits, next values
    // ********************************************************
    // Software writes first; an instruction in the same cycle wins on overflow
    always_comb begin
        user_flag_zero_next = user_flag_zero_reg;
        user_flag_one_next  = user_flag_one_reg;
        bank_select_next    = bank_select_reg;
        overflow_flag_next  = overflow_flag_reg;
        // Whole word write, parity and carry bits ignored
        if (wr_status) begin
            user_flag_zero_next = wr_data_i[sfw_pkg::BIT_USER_ZERO];
            user_flag_one_next  = wr_data_i[sfw_pkg::BIT_USER_ONE];
            bank_select_next    = {wr_data_i[sfw_pkg::BIT_BANK_HIGH],
                                   wr_data_i[sfw_pkg::BIT_BANK_LOW]};
            overflow_flag_next  = wr_data_i[sfw_pkg::BIT_OVERFLOW];
        end
        // Single bit write
        if (wr_bit) begin
            case (bit_index)
                3'(sfw_pkg::BIT_USER_ZERO): begin
                    user_flag_zero_next = bit_value;
                end
                3'(sfw_pkg::BIT_USER_ONE): begin
                    user_flag_one_next = bit_value;
                end
                3'(sfw_pkg::BIT_BANK_HIGH): begin
                    bank_select_next[1] = bit_value;
                end
                3'(sfw_pkg::BIT_BANK_LOW): begin
                    bank_select_next[0] = bit_value;
                end
                3'(sfw_pkg::BIT_OVERFLOW): begin
                    overflow_flag_next = bit_value;
                end
                default: begin
                    overflow_flag_next = overflow_flag_next;  // Parity, carry: no effect
                end
            endcase
        end
        // Each arithmetic instruction sets or clears overflow
        if (op_valid_i) begin
            overflow_flag_next = op_overflow;
        end
    end

    // Status bits, registered
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            user_flag_zero_reg <= sfw_pkg::RST_FLAG;
            user_flag_one_reg  <= sfw_pkg::RST_FLAG;
            bank_select_reg    <= sfw_pkg::RST_BANK;
            overflow_flag_reg  <= sfw_pkg::RST_FLAG;
        end else begin
            user_flag_zero_reg <= user_flag_zero_next;
            user_flag_one_reg  <= user_flag_one_next;
            bank_select_reg    <= bank_select_next;
            overflow_flag_reg  <= overflow_flag_next;
        end
    end

    // ********************************************************
    // Output images, next values
    // ********************************************************
    // Built from next values so outputs match the bits one edge on
    always_comb begin
        parity_next      = parity_now;
        bank_base_next   = 8'({bank_select_next, 3'h0});
        status_word_next = 8'h00;
        status_word_next[sfw_pkg::BIT_USER_ZERO] = user_flag_zero_next;
        status_word_next[sfw_pkg::BIT_BANK_HIGH] = bank_select_next[1];
        status_word_next[sfw_pkg::BIT_BANK_LOW]  = bank_select_next[0];
        status_word_next[sfw_pkg::BIT_OVERFLOW]  = overflow_flag_next;
        status_word_next[sfw_pkg::BIT_USER_ONE]  = user_flag_one_next;
        status_word_next[sfw_pkg::BIT_PARITY]    = parity_now;
    end

    // Output images, registered
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            parity_reg      <= sfw_pkg::RST_FLAG;
            bank_base_reg   <= sfw_pkg::RST_DATA;
            status_word_reg <= sfw_pkg::RST_DATA;
        end else begin
            parity_reg      <= parity_next;
            bank_base_reg   <= bank_base_next;
            status_word_reg <= status_word_next;
        end
    end

    // ********************************************************
    // Read path
    // ********************************************************
    // Data valid only in the cycle after the strobe, zero otherwise
    always_comb begin
        rd_data_next = sfw_pkg::RST_DATA;
        if (rd_strobe_i) begin
            case (addr_i)
                sfw_pkg::OFF_STATUS: begin
                    rd_data_next = 8'h00;
                    rd_data_next[sfw_pkg::BIT_USER_ZERO] = user_flag_zero_reg;
                    rd_data_next[sfw_pkg::BIT_BANK_HIGH] = bank_select_reg[1];
                    rd_data_next[sfw_pkg::BIT_BANK_LOW]  = bank_select_reg[0];
                    rd_data_next[sfw_pkg::BIT_OVERFLOW]  = overflow_flag_reg;
                    rd_data_next[sfw_pkg::BIT_USER_ONE]  = user_flag_one_reg;
                    rd_data_next[sfw_pkg::BIT_PARITY]    = parity_now;
                end
                sfw_pkg::OFF_BANK_BASE: begin
                    rd_data_next = 8'({bank_select_reg, 3'h0});
                end
                default: begin
                    rd_data_next = sfw_pkg::RST_DATA;    // Unmapped and write-only
                end
            endcase
        end
    end

    // Read data, registered
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_reg <= sfw_pkg::RST_DATA;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign rd_data_o        = rd_data_reg;
    assign user_flag_zero_o = user_flag_zero_reg;
    assign user_flag_one_o  = user_flag_one_reg;
    assign bank_select_o    = bank_select_reg;
    assign bank_base_o      = bank_base_reg;
    assign overflow_flag_o  = overflow_flag_reg;
    assign parity_flag_o    = parity_reg;
    assign status_word_o    = status_word_reg;

endmodule

/* verification/sfw_status_word_asserts.sv */
/* Checker for the status flags word: overflow, parity, flags, bank.
   Assumes it is bound to sfw_status_word and sees its ports only. */
`timescale 1ns/100ps

module sfw_status_word_asserts (
    // Clock and reset
    input wire logic             clock_i,
    input wire logic             reset_n_i,
    // Register port and datapath inputs
    input wire logic [7:0]       addr_i,
    input wire logic             wr_strobe_i, rd_strobe_i, op_valid_i, carry_in_i,
    input wire sfw_pkg::sfw_op_e op_kind_i,
    input wire logic [7:0]       operand_a_i, operand_b_i, accumulator_i,
    // Design outputs
    input wire logic [7:0]       rd_data_o, bank_base_o, status_word_o,
    input wire logic             user_flag_zero_o, user_flag_one_o,
    input wire logic [1:0]       bank_select_o,
    input wire logic             overflow_flag_o, parity_flag_o
);
    // ************************************************
    // Helper logic
    // ************************************************
    logic        up_reg;
    int          sum_s;
    int          dif_s;
    int          prod_s;
    logic        add_ovf, sub_ovf, prod_ovf, par_w;
    logic [7:0]  img_w;

    // Expected overflow per instruction and live word image
    always_comb begin
        // Signed results outside the byte range mean overflow
        sum_s    = int'($signed(operand_a_i)) + int'($signed(operand_b_i))
                 + int'(carry_in_i && (op_kind_i == sfw_pkg::SFW_OP_SUM_WITH_CARRY));
        dif_s    = int'($signed(operand_a_i)) - int'($signed(operand_b_i)) - int'(carry_in_i);
        prod_s   = int'(operand_a_i) * int'(operand_b_i);
        add_ovf  = (sum_s > 127) || (sum_s < -128);
        sub_ovf  = (dif_s > 127) || (dif_s < -128);
        prod_ovf = prod_s > int'(sfw_pkg::PRODUCT_LIMIT);
        par_w  = ^accumulator_i;
        img_w  = {2'h0, status_word_o[5:1], par_w};
    end

    // Marks that one edge has passed since reset
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            up_reg <= 1'b0;
        end else begin
            up_reg <= 1'b1;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    // ************************************************
    // Assertions
    // ************************************************
    flags_sw_only_a : assert property (!wr_strobe_i |=>
        $stable({user_flag_zero_o, user_flag_one_o})) else $error("user flag moved");
    bank_base_map_a : assert property (bank_base_o == {bank_select_o, 3'h0})
        else $error("bank base mismatch");
    add_overflow_a : assert property (op_valid_i && (op_kind_i == sfw_pkg::SFW_OP_ADD
        || op_kind_i == sfw_pkg::SFW_OP_SUM_WITH_CARRY) |=> overflow_flag_o == $past(add_ovf))
        else $error("add overflow wrong");
    sub_overflow_a : assert property (op_valid_i &&
        op_kind_i == sfw_pkg::SFW_OP_SUBTRACT_WITH_BORROW |=> overflow_flag_o == $past(sub_ovf))
        else $error("subtract overflow wrong");
    product_overflow_a : assert property (op_valid_i
        && op_kind_i == sfw_pkg::SFW_OP_PRODUCT
        |=> overflow_flag_o == $past(prod_ovf)) else $error("product overflow wrong");
    div_zero_a : assert property (op_valid_i && op_kind_i == sfw_pkg::SFW_OP_DIVIDE
        && operand_b_i == 8'h00 |=> overflow_flag_o) else $error("divide by zero missed");
    div_clear_a : assert property (op_valid_i && op_kind_i == sfw_pkg::SFW_OP_DIVIDE
        && operand_b_i != 8'h00 |=> !overflow_flag_o) else $error("divide overflow kept");
    parity_lag_a : assert property (up_reg |-> parity_flag_o == $past(par_w))
        else $error("parity flag wrong");
    read_live_a : assert property (rd_strobe_i && addr_i == sfw_pkg::OFF_STATUS
        |=> rd_data_o == $past(img_w)) else $error("status read wrong");

    // Main scenarios reached
    ovf_set_c : cover property (op_valid_i ##1 overflow_flag_o);
    bank_top_c : cover property (bank_select_o == 2'h3);
    odd_read_c : cover property (rd_strobe_i ##1 rd_data_o[0]);
endmodule

bind sfw_status_word sfw_status_word_asserts u_chk (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wr_strobe_i(wr_strobe_i), .rd_strobe_i(rd_strobe_i), .op_valid_i(op_valid_i),
    .carry_in_i(carry_in_i), .op_kind_i(op_kind_i), .operand_a_i(operand_a_i),
    .operand_b_i(operand_b_i), .accumulator_i(accumulator_i), .rd_data_o(rd_data_o),
    .bank_base_o(bank_base_o), .status_word_o(status_word_o),
    .user_flag_zero_o(user_flag_zero_o), .user_flag_one_o(user_flag_one_o),
    .bank_select_o(bank_select_o), .overflow_flag_o(overflow_flag_o),
    .parity_flag_o(parity_flag_o));

/* verification/sfw_status_word_tb.sv */
/* Self-checking bench for the status flags word.
   Assumes the checker is bound in and the register port never stalls. */
`timescale 1ns/100ps

module sfw_status_word_tb;
    logic             clock_i = 1'b0, reset_n_i = 1'b0;
    logic             wr_strobe_i = 1'b0, rd_strobe_i = 1'b0;
    logic             op_valid_i = 1'b0, carry_in_i = 1'b0;
    logic [7:0]       addr_i = 8'h00, wr_data_i = 8'h00, accumulator_i = 8'h00;
    logic [7:0]       operand_a_i = 8'h00, operand_b_i = 8'h00;
    sfw_pkg::sfw_op_e op_kind_i = sfw_pkg::SFW_OP_ADD;
    logic [7:0]       rd_data_o, bank_base_o, status_word_o;
    logic             user_flag_zero_o, user_flag_one_o, overflow_flag_o, parity_flag_o;
    logic [1:0]       bank_select_o;
    int               miscompares = 0;
    int               checks = 0;

    // Core clock, 5 ns period
    always #2.5 clock_i = ~clock_i;

    sfw_status_word DUT (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
        .wr_strobe_i(wr_strobe_i), .rd_strobe_i(rd_strobe_i), .rd_data_o(rd_data_o),
        .op_valid_i(op_valid_i), .op_kind_i(op_kind_i), .operand_a_i(operand_a_i),
        .operand_b_i(operand_b_i), .carry_in_i(carry_in_i), .accumulator_i(accumulator_i),
        .user_flag_zero_o(user_flag_zero_o), .user_flag_one_o(user_flag_one_o),
        .bank_select_o(bank_select_o), .bank_base_o(bank_base_o),
        .overflow_flag_o(overflow_flag_o), .parity_flag_o(parity_flag_o),
        .status_word_o(status_word_o));

    // Compare and count
    task cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One-cycle register write
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_strobe_i <= 1'b1;
        @(posedge clock_i);
        wr_strobe_i <= 1'b0;
        @(negedge clock_i);
    endtask

    // One-cycle register read, data judged in the next cycle
    task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clock_i);
        addr_i <= a;
        rd_strobe_i <= 1'b1;
        @(posedge clock_i);
        rd_strobe_i <= 1'b0;
        @(negedge clock_i);
        cmp(rd_data_o, exp, what);
    endtask

    // Software flags, bit access and read-only bits
    task s_flags;
        rd(sfw_pkg::OFF_STATUS, 8'h00, "reset word");
        wr(sfw_pkg::OFF_STATUS, 8'he3);
        cmp(status_word_o, 8'h22, "word image flags");
        rd(sfw_pkg::OFF_STATUS, 8'h22, "flags set");
        @(negedge clock_i);
        cmp(rd_data_o, 8'h00, "read data dropped");
        wr(sfw_pkg::OFF_BIT_ACCESS, 8'h05);
        wr(sfw_pkg::OFF_BIT_ACCESS, 8'h0f);
        cmp({7'h00, user_flag_zero_o}, 8'h00, "flag zero cleared");
        wr(sfw_pkg::OFF_BIT_ACCESS, 8'h01);
        rd(sfw_pkg::OFF_STATUS, 8'h00, "flag one cleared");
        wr(sfw_pkg::OFF_BIT_ACCESS, 8'h0c);
        wr(sfw_pkg::OFF_BIT_ACCESS, 8'h0b);
        wr(sfw_pkg::OFF_BIT_ACCESS, 8'h0a);
        rd(sfw_pkg::OFF_STATUS, 8'h1c, "bank and overflow bits");
    endtask

    // Every bank selector value and its window
    task s_bank;
        for (int i = 0; i < 4; i++) begin
            wr(sfw_pkg::OFF_STATUS, 8'(i * 8));
            cmp({6'h00, bank_select_o}, 8'(i), "bank select");
            cmp(bank_base_o, 8'(i * 8), "bank base");
            cmp(status_word_o, 8'(i * 8), "word image bank");
            rd(sfw_pkg::OFF_BANK_BASE, 8'(i * 8), "bank base read");
        end
        wr(sfw_pkg::OFF_STATUS, 8'h00);
    endtask

    // Back-to-back instructions, overflow set and cleared
    task s_ops;
        sfw_pkg::sfw_op_e k [11];
        logic [7:0]       a [11];
        logic [7:0]       b [11];
        logic             c [11];
        logic             e [11];
        k = '{sfw_pkg::SFW_OP_ADD, sfw_pkg::SFW_OP_ADD, sfw_pkg::SFW_OP_SUM_WITH_CARRY,
              sfw_pkg::SFW_OP_SUM_WITH_CARRY, sfw_pkg::SFW_OP_SUBTRACT_WITH_BORROW,
              sfw_pkg::SFW_OP_SUBTRACT_WITH_BORROW, sfw_pkg::SFW_OP_SUBTRACT_WITH_BORROW,
              sfw_pkg::SFW_OP_PRODUCT, sfw_pkg::SFW_OP_PRODUCT,
              sfw_pkg::SFW_OP_DIVIDE, sfw_pkg::SFW_OP_DIVIDE};
        a = '{8'h7f, 8'h7f, 8'h7f, 8'hff, 8'h80, 8'h00, 8'h7f, 8'h10, 8'h0f, 8'h10, 8'h10};
        b = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h10, 8'h11, 8'h00, 8'h02};
        c = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        e = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 12; i++) begin
            @(posedge clock_i);
            op_valid_i <= (i < 11);
            op_kind_i <= k[i % 11];
            operand_a_i <= a[i % 11];
            operand_b_i <= b[i % 11];
            carry_in_i <= c[i % 11];
            @(negedge clock_i);
            if (i > 0) begin
                cmp({7'h00, overflow_flag_o}, {7'h00, e[i - 1]}, "overflow");
            end
        end
        // Software write and instruction in one cycle: instruction wins
        @(posedge clock_i);
        addr_i <= sfw_pkg::OFF_BIT_ACCESS;
        wr_data_i <= 8'h0a;
        wr_strobe_i <= 1'b1;
        op_valid_i <= 1'b1;
        op_kind_i <= sfw_pkg::SFW_OP_DIVIDE;
        operand_b_i <= 8'h02;
        @(posedge clock_i);
        wr_strobe_i <= 1'b0;
        op_valid_i <= 1'b0;
        @(negedge clock_i);
        cmp({7'h00, overflow_flag_o}, 8'h00, "instruction beats write");
    endtask

    // Unmapped and read-only places
    task s_unmapped;
        wr(8'h05, 8'hff);
        wr(sfw_pkg::OFF_BANK_BASE, 8'hff);
        rd(sfw_pkg::OFF_STATUS, 8'h00, "word after ignored writes");
        rd(8'h05, 8'h00, "unmapped read");
        rd(sfw_pkg::OFF_BIT_ACCESS, 8'h00, "bit access read");
    endtask

    // Parity follows the accumulator, live in reads
    task s_parity;
        logic [7:0] v [6];
        v = '{8'h00, 8'h01, 8'h03, 8'h80, 8'hfe, 8'h7f};
        for (int i = 0; i < 6; i++) begin
            @(posedge clock_i);
            accumulator_i <= v[i];
            addr_i <= sfw_pkg::OFF_STATUS;
            rd_strobe_i <= 1'b1;
            @(posedge clock_i);
            rd_strobe_i <= 1'b0;
            @(negedge clock_i);
            cmp({7'h00, parity_flag_o}, {7'h00, ^v[i]}, "parity flag");
            cmp(rd_data_o, {7'h00, ^v[i]}, "live parity read");
            cmp(status_word_o, {7'h00, ^v[i]}, "word image parity");
        end
    endtask

    // Verdict and end of run
    task stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clock_i);
        reset_n_i <= 1'b1;
        s_flags();
        s_bank();
        s_ops();
        s_unmapped();
        s_parity();
        stop_test();
    end
endmodule
